// ---- pkg/uart_pkg.sv ----
// Package: register map, field positions, reset values and timing for the serial unit
package uart_pkg;
  // Register byte offsets (word aligned)
  localparam logic [4:0] mode_off     = 5'h00;
  localparam logic [4:0] err_off      = 5'h04;
  localparam logic [4:0] rxbuf_off    = 5'h08;
  localparam logic [4:0] txshift_off  = 5'h0c;
  localparam logic [4:0] baud_off     = 5'h10;
  localparam logic [4:0] irq_stat_off = 5'h14;
  localparam logic [4:0] irq_mask_off = 5'h18;
  // Mode register fields
  localparam int pwr_bit  = 7;
  localparam int txe_bit  = 6;
  localparam int rxe_bit  = 5;
  localparam int psh_bit  = 4;
  localparam int psl_bit  = 3;
  localparam int cl_bit   = 2;
  localparam int sl_bit   = 1;
  localparam int one_bit  = 0;
  localparam logic [7:0] mode_reset = 8'h01;
  // Error status fields
  localparam int pe_bit = 2;
  localparam int fe_bit = 1;
  localparam int ov_bit = 0;
  // Interrupt status fields
  localparam int irq_tx_bit  = 0;
  localparam int irq_rx_bit  = 1;
  localparam int irq_err_bit = 2;
  // Baud divisor reset (base clock ticks per bit) and base clock divider compare value
  localparam logic [7:0] baud_reset = 8'h10;
  localparam logic [7:0] base_div   = 8'h01;
  // Minimum base clock ticks between disable and re-enable
  localparam logic [1:0] reen_ticks = 2'h2;
  // Parity modes
  localparam logic [1:0] par_none = 2'h0;
  localparam logic [1:0] par_zero = 2'h1;
  localparam logic [1:0] par_odd  = 2'h2;
  localparam logic [1:0] par_even = 2'h3;
endpackage

// ---- verilog/uart_tx.sv ----
// Serial transmitter shift engine
`timescale 1ns/1ps
module uart_tx
  import uart_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic [7:0] bit_div,
  input  wire logic [1:0] parity,
  input  wire logic       len8,
  input  wire logic       two_stop,
  input  wire logic       load,
  input  wire logic [7:0] data,
  // Outputs
  output logic            txd,
  output logic            done
);
  typedef enum logic [2:0] {t_idle, t_start, t_data, t_par, t_stop} tx_state_e;
  tx_state_e   state, next_state;
  logic [7:0]  shreg, next_shreg;
  logic [7:0]  cnt, next_cnt;
  logic [3:0]  nbit, next_nbit;
  logic        par, next_par;
  logic        next_txd, next_done;

  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_cnt   = cnt;
    next_nbit  = nbit;
    next_par   = par;
    next_txd   = txd;
    next_done  = 1'b0;
    if (!enable)
    begin
      // Disabled circuit is held initialised
      next_state = t_idle;
      next_txd   = 1'b1;
      next_cnt   = 8'h00;
    end
    else if (state == t_idle)
    begin
      if (load)
      begin
        next_state = t_start;
        next_shreg = data;
        next_par   = 1'b0;
        next_cnt   = 8'h00;
        next_nbit  = 4'h0;
        next_txd   = 1'b0;
      end
    end
    else if (tick)
    begin
      if (cnt != bit_div - 8'h01)
        next_cnt = cnt + 8'h01;
      else
      begin
        next_cnt = 8'h00;
        case (state)
          t_start, t_data:
          begin
            if (state == t_data && nbit == (len8 ? 4'h8 : 4'h7))
            begin
              next_state = (parity == par_none) ? t_stop : t_par;
              next_nbit  = 4'h0;
              case (parity)
                par_zero: next_txd = 1'b0;
                par_odd:  next_txd = ~par;
                par_even: next_txd = par;
                default:  next_txd = 1'b1;
              endcase
            end
            else
            begin
              next_state = t_data;
              next_txd   = shreg[0];
              next_par   = par ^ shreg[0];
              next_shreg = {1'b0, shreg[7:1]};
              next_nbit  = nbit + 4'h1;
            end
          end
          t_par:
          begin
            next_state = t_stop;
            next_txd   = 1'b1;
          end
          t_stop:
          begin
            next_txd = 1'b1;
            if (nbit == {3'h0, two_stop})
            begin
              next_state = t_idle;
              next_done  = 1'b1;
            end
            else
              next_nbit = nbit + 4'h1;
          end
          default: next_state = t_idle;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= t_idle;
      shreg <= 8'h00;
      cnt   <= 8'h00;
      nbit  <= 4'h0;
      par   <= 1'b0;
      txd   <= 1'b1;
      done  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      shreg <= next_shreg;
      cnt   <= next_cnt;
      nbit  <= next_nbit;
      par   <= next_par;
      txd   <= next_txd;
      done  <= next_done;
    end
  end
endmodule

// ---- verilog/uart_rx.sv ----
// Serial receiver with single stop bit check and parity check
`timescale 1ns/1ps
module uart_rx
  import uart_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic [7:0] bit_div,
  input  wire logic [1:0] parity,
  input  wire logic       len8,
  input  wire logic       rxd,
  // Received character
  output logic            valid,
  output logic [7:0]      data,
  output logic            par_err,
  output logic            frm_err
);
  typedef enum logic [2:0] {r_idle, r_start, r_data, r_par, r_stop} rx_state_e;
  rx_state_e   state, next_state;
  logic [7:0]  shreg, next_shreg;
  logic [7:0]  cnt, next_cnt;
  logic [3:0]  nbit, next_nbit;
  logic        par, next_par;
  logic        pbad, next_pbad;
  logic        next_valid, next_perr, next_ferr;
  logic [7:0]  next_data;
  logic        mid, last;

  assign mid  = (cnt == {1'b0, bit_div[7:1]});
  assign last = (cnt == bit_div - 8'h01);

  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_cnt   = cnt;
    next_nbit  = nbit;
    next_par   = par;
    next_pbad  = pbad;
    next_valid = 1'b0;
    next_data  = data;
    next_perr  = par_err;
    next_ferr  = frm_err;
    if (!enable)
    begin
      next_state = r_idle;
      next_cnt   = 8'h00;
    end
    else if (state == r_idle)
    begin
      // A low line at enable starts a frame at once
      if (!rxd)
      begin
        next_state = r_start;
        next_cnt   = 8'h00;
        next_nbit  = 4'h0;
        next_par   = 1'b0;
        next_shreg = 8'h00;
      end
    end
    else if (tick)
    begin
      next_cnt = last ? 8'h00 : cnt + 8'h01;
      if (mid)
      begin
        case (state)
          r_start: next_state = rxd ? r_idle : r_data;
          r_data:
          begin
            next_shreg = len8 ? {rxd, shreg[7:1]} : {1'b0, rxd, shreg[6:1]};
            next_par   = par ^ rxd;
            next_nbit  = nbit + 4'h1;
            if (nbit == (len8 ? 4'h7 : 4'h6))
              next_state = (parity == par_none) ? r_stop : r_par;
          end
          r_par:
          begin
            // Check depends on parity mode
            case (parity)
              par_zero: next_pbad = 1'b0;
              par_odd:  next_pbad = ~(par ^ rxd);
              par_even: next_pbad = par ^ rxd;
              default:  next_pbad = 1'b0;
            endcase
            next_state = r_stop;
          end
          r_stop:
          begin
            // Only first stop bit sampled; a second one is ignored
            next_state = r_idle;
            next_valid = 1'b1;
            next_data  = shreg;
            next_ferr  = ~rxd;
            next_perr  = (parity == par_none) ? 1'b0 : pbad;
            next_pbad  = 1'b0;
          end
          default: next_state = r_idle;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state   <= r_idle;
      shreg   <= 8'h00;
      cnt     <= 8'h00;
      nbit    <= 4'h0;
      par     <= 1'b0;
      pbad    <= 1'b0;
      valid   <= 1'b0;
      data    <= 8'h00;
      par_err <= 1'b0;
      frm_err <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      shreg   <= next_shreg;
      cnt     <= next_cnt;
      nbit    <= next_nbit;
      par     <= next_par;
      pbad    <= next_pbad;
      valid   <= next_valid;
      data    <= next_data;
      par_err <= next_perr;
      frm_err <= next_ferr;
    end
  end
endmodule

// ---- verilog/uart_mode_control.sv ----
// Serial unit top: Wishbone registers, enable sequencing, error status and interrupts
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module uart_mode_control
  import uart_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Serial lines
  input  wire logic        serial_receive_input,
  output logic             serial_transmit_output,
  // Interrupt
  output logic             irq
);
  // Registers
  logic [7:0]  serial_mode_register;
  logic [7:0]  next_mode;
  logic [7:0]  baud_generator_control;
  logic [7:0]  next_baud;
  logic [2:0]  reception_error_status;
  logic [2:0]  next_err;
  logic [7:0]  receive_buffer;
  logic [7:0]  next_rxbuf;
  logic [2:0]  irq_stat;
  logic [2:0]  next_irq_stat;
  logic [2:0]  irq_mask;
  logic [2:0]  next_irq_mask;
  // Base clock and enable sequencing
  logic [7:0]  base_cnt;
  logic [7:0]  next_base_cnt;
  logic        base_tick;
  logic        tx_en_s;
  logic        next_tx_en_s;
  logic        rx_en_s;
  logic        next_rx_en_s;
  logic [1:0]  tx_off_cnt;
  logic [1:0]  next_tx_off_cnt;
  logic [1:0]  rx_off_cnt;
  logic [1:0]  next_rx_off_cnt;
  // Transmit hand-off
  logic        tx_load;
  logic        next_tx_load;
  logic [7:0]  tx_data;
  logic [7:0]  next_tx_data;
  // Bus answer
  logic        ack;
  logic        next_ack;
  logic        wait_done;
  logic        next_wait_done;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        req;
  logic        wr;
  logic        rd;
  logic        lane0;
  logic        err_rd;
  // Engine outputs
  logic        tx_txd;
  logic        tx_done;
  logic        rx_valid;
  logic        rx_perr;
  logic        rx_ferr;
  logic [7:0]  rx_data;
  // Mode bits
  logic        unit_power_bit;
  logic        transmit_enable_bit;
  logic        receive_enable_bit;

  assign unit_power_bit      = serial_mode_register[pwr_bit];
  assign transmit_enable_bit = serial_mode_register[txe_bit];
  assign receive_enable_bit  = serial_mode_register[rxe_bit];

  // Ack in req stops a held request being taken twice
  assign req    = wb_cyc_i && wb_stb_i && !ack;
  assign err_rd = req && !wb_we_i && wb_adr_i == err_off;
  // Error status read holds ack back one cycle
  assign rd     = req && !wb_we_i && (!err_rd || wait_done);
  assign wr     = req && wb_we_i;
  assign lane0  = wb_sel_i[0];
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign irq      = |(irq_stat & irq_mask);
  assign serial_transmit_output = tx_txd;

  // Base clock divider; other clock sources are not modelled
  assign base_tick = unit_power_bit && (base_cnt == base_div);

  always_comb
  begin
    next_base_cnt   = (!unit_power_bit || base_tick) ? 8'h00 : base_cnt + 8'h01;
    next_tx_en_s    = tx_en_s;
    next_rx_en_s    = rx_en_s;
    next_tx_off_cnt = tx_off_cnt;
    next_rx_off_cnt = rx_off_cnt;
    if (base_tick)
    begin
      // Enables taken on base ticks; a circuit re-arms only after two low ticks
      // A re-enable that comes too early leaves the circuit off until cleared again
      if (!(transmit_enable_bit && unit_power_bit))
      begin
        next_tx_en_s = 1'b0;
        if (tx_off_cnt != reen_ticks)
          next_tx_off_cnt = tx_off_cnt + 2'h1;
      end
      else if (tx_off_cnt == reen_ticks || tx_en_s)
      begin
        next_tx_en_s    = 1'b1;
        next_tx_off_cnt = 2'h0;
      end
      if (!(receive_enable_bit && unit_power_bit))
      begin
        next_rx_en_s = 1'b0;
        if (rx_off_cnt != reen_ticks)
          next_rx_off_cnt = rx_off_cnt + 2'h1;
      end
      else if (rx_off_cnt == reen_ticks || rx_en_s)
      begin
        next_rx_en_s    = 1'b1;
        next_rx_off_cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      base_cnt   <= 8'h00;
      tx_en_s    <= 1'b0;
      rx_en_s    <= 1'b0;
      tx_off_cnt <= reen_ticks;
      rx_off_cnt <= reen_ticks;
    end
    else
    begin
      base_cnt   <= next_base_cnt;
      tx_en_s    <= next_tx_en_s;
      rx_en_s    <= next_rx_en_s;
      tx_off_cnt <= next_tx_off_cnt;
      rx_off_cnt <= next_rx_off_cnt;
    end
  end

  // Register file and bus answer
  always_comb
  begin
    next_mode      = serial_mode_register;
    next_baud      = baud_generator_control;
    next_err       = reception_error_status;
    next_rxbuf     = receive_buffer;
    next_irq_stat  = irq_stat;
    next_irq_mask  = irq_mask;
    next_tx_load   = 1'b0;
    next_tx_data   = tx_data;
    next_ack       = rd || wr;
    next_wait_done = err_rd && !wait_done;
    next_rdata     = rdata;
    if (wr && lane0)
    begin
      case (wb_adr_i)
        // Bit zero stored as written; software must keep it one
        mode_off:     next_mode = wb_dat_i[7:0];
        baud_off:     next_baud = (wb_dat_i[7:0] == 8'h00) ? 8'h01 : wb_dat_i[7:0];
        irq_mask_off: next_irq_mask = wb_dat_i[2:0];
        txshift_off:
        begin
          // Caller waits for transmit done before the next write
          next_tx_data = wb_dat_i[7:0];
          next_tx_load = 1'b1;
        end
        default: next_mode = serial_mode_register;
      endcase
    end
    if (rd)
    begin
      case (wb_adr_i)
        mode_off:     next_rdata = {24'h0, serial_mode_register};
        err_off:      next_rdata = {29'h0, reception_error_status};
        rxbuf_off:    next_rdata = {24'h0, receive_buffer};
        baud_off:     next_rdata = {24'h0, baud_generator_control};
        irq_stat_off: next_rdata = {29'h0, irq_stat};
        irq_mask_off: next_rdata = {29'h0, irq_mask};
        default:      next_rdata = 32'h0;
      endcase
      // Reading the buffer clears the errors it carried
      if (wb_adr_i == rxbuf_off)
        next_err = 3'h0;
      if (wb_adr_i == irq_stat_off)
        next_irq_stat = 3'h0;
    end
    if (rx_valid)
    begin
      // Overrun blocks the buffer until it is read
      if (reception_error_status[ov_bit] || irq_stat[irq_rx_bit])
      begin
        if (!(rd && wb_adr_i == rxbuf_off) || reception_error_status[ov_bit])
          next_err[ov_bit] = 1'b1;
        else
        begin
          next_rxbuf = rx_data;
          next_err   = {rx_perr, rx_ferr, 1'b0};
        end
      end
      else
      begin
        next_rxbuf       = rx_data;
        next_err[pe_bit] = rx_perr;
        next_err[fe_bit] = rx_ferr;
      end
      next_irq_stat[irq_rx_bit] = 1'b1;
      if (rx_perr || rx_ferr || reception_error_status[ov_bit] || irq_stat[irq_rx_bit])
        next_irq_stat[irq_err_bit] = 1'b1;
    end
    if (tx_done)
      next_irq_stat[irq_tx_bit] = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      serial_mode_register   <= mode_reset;
      baud_generator_control <= baud_reset;
      reception_error_status <= 3'h0;
      receive_buffer         <= 8'h00;
      irq_stat               <= 3'h0;
      irq_mask               <= 3'h0;
      tx_load                <= 1'b0;
      tx_data                <= 8'h00;
      ack                    <= 1'b0;
      wait_done              <= 1'b0;
      rdata                  <= 32'h0;
    end
    else
    begin
      serial_mode_register   <= next_mode;
      baud_generator_control <= next_baud;
      reception_error_status <= next_err;
      receive_buffer         <= next_rxbuf;
      irq_stat               <= next_irq_stat;
      irq_mask               <= next_irq_mask;
      tx_load                <= next_tx_load;
      tx_data                <= next_tx_data;
      ack                    <= next_ack;
      wait_done              <= next_wait_done;
      rdata                  <= next_rdata;
    end
  end

  // Format bits are used live; changing them while enabled is unsafe
  uart_tx u_tx (
    .clk      (clk),
    .rst      (rst),
    .enable   (tx_en_s),
    .tick     (base_tick),
    .bit_div  (baud_generator_control),
    .parity   (serial_mode_register[psh_bit:psl_bit]),
    .len8     (serial_mode_register[cl_bit]),
    .two_stop (serial_mode_register[sl_bit]),
    .load     (tx_load),
    .data     (tx_data),
    .txd      (tx_txd),
    .done     (tx_done)
  );

  uart_rx u_rx (
    .clk     (clk),
    .rst     (rst),
    .enable  (rx_en_s),
    .tick    (base_tick),
    .bit_div (baud_generator_control),
    .parity  (serial_mode_register[psh_bit:psl_bit]),
    .len8    (serial_mode_register[cl_bit]),
    .rxd     (serial_receive_input),
    .valid   (rx_valid),
    .data    (rx_data),
    .par_err (rx_perr),
    .frm_err (rx_ferr)
  );
endmodule

// ---- testbench/uart_mode_control_monitor.sv ----
// Checker for bus timing, readback and interrupt masking of the serial unit
`timescale 1ns/1ps
module uart_mode_control_monitor
  import uart_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Serial and interrupt
  input wire logic        serial_receive_input,
  input wire logic        serial_transmit_output,
  input wire logic        irq
);
  logic       wr;
  logic [7:0] mode_sh;
  logic [7:0] mask_sh;
  logic [3:0] off_cnt;
  logic [7:0] next_mode_sh;
  logic [7:0] next_mask_sh;
  logic [3:0] next_off_cnt;
  // Shadows follow bus writes so readback needs no view inside
  always_comb
  begin
    wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    next_mode_sh = (wr && wb_adr_i == mode_off) ? wb_dat_i[7:0] : mode_sh;
    next_mask_sh = (wr && wb_adr_i == irq_mask_off) ? wb_dat_i[7:0] : mask_sh;
    next_off_cnt = mode_sh[txe_bit] ? 4'h0 : ((off_cnt == 4'hf) ? off_cnt : off_cnt + 4'h1);
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_sh <= mode_reset;
      mask_sh <= 8'h00;
      off_cnt <= 4'h0;
    end
    else
    begin
      mode_sh <= next_mode_sh;
      mask_sh <= next_mask_sh;
      off_cnt <= next_off_cnt;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_inside_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_plain_ack_latency: assert property ($rose(wb_stb_i) && wb_cyc_i && !(wb_adr_i == err_off && !wb_we_i)
    |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_err_read_wait: assert property ($rose(wb_stb_i) && wb_cyc_i && !wb_we_i && wb_adr_i == err_off
    |=> !wb_ack_o ##1 wb_ack_o)
    else $error("error status read without one wait cycle");
  a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i && (wb_adr_i > irq_mask_off || wb_adr_i == txshift_off)
    |-> wb_dat_o == 32'h00000000)
    else $error("unmapped or write only read not zero");
  a_mode_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i == mode_off |-> wb_dat_o[7:0] == mode_sh)
    else $error("mode readback differs");
  a_irq_masked_off: assert property (mask_sh == 8'h00 |-> !irq)
    else $error("irq with all sources masked");
  a_tx_idle_disabled: assert property (off_cnt == 4'hf |-> serial_transmit_output)
    else $error("transmit line not idle while disabled");
  c_err_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == err_off);
  c_irq_high: cover property (irq);
  c_tx_frame: cover property ($fell(serial_transmit_output));
  c_rx_enable: cover property ($rose(mode_sh[rxe_bit]));
endmodule

bind uart_mode_control uart_mode_control_monitor u_mon (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_receive_input(serial_receive_input),
  .serial_transmit_output(serial_transmit_output), .irq(irq));

// ---- testbench/serial_partner.sv ----
// Remote serial partner: frame sender on the receive line, frame catcher on the transmit line
`timescale 1ns/1ps
module serial_partner
#(
  parameter int bit_clks = 16
)
(
  // Clock
  input  wire logic  clk,
  // Serial lines
  input  wire logic  txd,
  output logic       rxd,
  // Last caught character
  output logic [7:0] got,
  output int         got_n
);
  initial
  begin
    rxd = 1'b1;
    got = 8'h00;
    got_n = 0;
  end
  // LSB first; the last bit is a stop bit, so the line is left idle high
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd <= bits[i];
      repeat (bit_clks) @(posedge clk);
    end
  endtask
  // Samples mid bit; a missing stop bit still updates got but leaves got_n uncounted
  always @(negedge txd)
  begin
    repeat (bit_clks + bit_clks / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      got[i] = txd;
      repeat (bit_clks) @(posedge clk);
    end
    if (txd === 1'b1)
      got_n++;
  end
endmodule

// ---- testbench/uart_mode_control_bench.sv ----
// Self-checking bench: register rows, reception, parity modes, overrun, transmission, reset
`timescale 1ns/1ps
module uart_mode_control_bench
  import uart_pkg::*;
;
  typedef struct packed { logic w; logic [4:0] a; logic [7:0] d; } row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        rxd;
  logic        txd;
  logic        irq;
  logic [7:0]  got;
  int          got_n;
  int          n_mismatch = 0;
  int          n_checks = 0;
  row_s        rows [0:11] = '{'{1'b0, mode_off, 8'h01}, '{1'b0, err_off, 8'h00}, '{1'b0, rxbuf_off, 8'h00},
    '{1'b0, txshift_off, 8'h00}, '{1'b0, baud_off, 8'h10}, '{1'b0, irq_stat_off, 8'h00},
    '{1'b0, irq_mask_off, 8'h00}, '{1'b0, 5'h1c, 8'h00}, '{1'b1, baud_off, 8'h08}, '{1'b0, baud_off, 8'h08},
    '{1'b1, irq_mask_off, 8'h06}, '{1'b0, irq_mask_off, 8'h06}};
  always #50 clk = ~clk;
  uart_mode_control u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .serial_receive_input(rxd),
    .serial_transmit_output(txd), .irq(irq));
  // Eight base ticks per bit at divisor 8, one base tick every two clocks: 8 x 2 = 16 clocks per bit
  serial_partner #(.bit_clks(16)) u_partner (.clk(clk), .txd(txd), .rxd(rxd), .got(got), .got_n(got_n));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Classic cycle held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50)
    begin
      n_mismatch++;
      print_verdict();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(what, q, {24'h0, e});
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 600)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 600)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i])
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
        rd_chk(rows[i].a, rows[i].d, "register row");
    $display("test registers done");
    // Line already low when reception is enabled
    wr(mode_off, 8'h85);
    fork
      u_partner.send({3'b111, 8'h00, 1'b0}, 10);
    join_none
    wr(mode_off, 8'ha5);
    repeat (190) @(posedge clk);
    rd_chk(irq_stat_off, 8'h02, "rx at low line");
    rd_chk(rxbuf_off, 8'h00, "rx data low line");
    $display("test early start done");
    // Parity bit sent as one in the three parity modes, none in mode 0; data has four ones
    for (int p = 0; p < 4; p++)
    begin
      wr(mode_off, 8'h85);
      repeat (8) @(posedge clk);
      wr(mode_off, {3'b101, 2'(p), 3'b101});
      u_partner.send({3'b111, 8'h5a, 1'b0}, (p == 0) ? 10 : 11);
      rd_chk(err_off, {5'h0, p == 3, 2'b00}, "parity flag");
      rd_chk(irq_stat_off, (p == 3) ? 8'h06 : 8'h02, "rx event");
      rd_chk(rxbuf_off, 8'h5a, "parity data");
      wr(mode_off, {3'b100, 2'(p), 3'b101});
    end
    $display("test parity modes done");
    // Two stop bits configured, frames sent with one
    wr(mode_off, 8'h85);
    repeat (8) @(posedge clk);
    wr(mode_off, 8'ha7);
    u_partner.send({3'b111, 8'h3c, 1'b0}, 10);
    u_partner.send({3'b111, 8'hc3, 1'b0}, 10);
    rd_chk(err_off, 8'h01, "overrun only");
    rd_chk(irq_stat_off, 8'h06, "overrun event");
    rd_chk(rxbuf_off, 8'h3c, "first kept");
    u_partner.send({3'b111, 8'h99, 1'b0}, 10);
    rd_chk(err_off, 8'h00, "error cleared");
    rd_chk(irq_stat_off, 8'h02, "rx resumed");
    rd_chk(rxbuf_off, 8'h99, "rx after read");
    $display("test overrun done");
    wr(mode_off, 8'h85);
    repeat (8) @(posedge clk);
    wr(irq_mask_off, 8'h01);
    wr(mode_off, 8'hc5);
    wr(txshift_off, 8'ha3);
    wait_irq();
    check("tx char", {24'h0, got}, 32'h000000a3);
    rd_chk(irq_stat_off, 8'h01, "tx done");
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(txshift_off, 8'h5c);
    wait_irq();
    check("tx second", {24'h0, got}, 32'h0000005c);
    check("tx count", got_n, 32'h2);
    wr(irq_mask_off, 8'h00);
    check("irq masked", {31'h0, irq}, 32'h0);
    rd_chk(irq_stat_off, 8'h01, "sticky under mask");
    $display("test transmit done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(mode_off, mode_reset, "mode after reset");
    rd_chk(baud_off, baud_reset, "baud after reset");
    $display("test reset done");
    print_verdict();
  end
endmodule
